// file: lgi_irq_ctrl.sv
// Purpose: Link and IMA group interrupt status and enable hierarchy with an AHB-Lite slave.
// Assumes: Single word transfers; event inputs arrive from logic on hclk.
// Notes: Reads take one wait state so a read always sees the latest write.
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
module lgi_irq_ctrl #(
	parameter int LINKS = lgi_pkg::N_LINKS
) (
	// Clock and reset
	input  wire logic                                          hclk,
	input  wire logic                                          hresetn,
	// AHB-Lite slave
	input  wire logic                                          hsel,
	input  wire logic [31:0]                                   haddr,
	input  wire logic [1:0]                                    htrans,
	input  wire logic                                          hwrite,
	input  wire logic [2:0]                                    hsize,
	input  wire logic [31:0]                                   hwdata,
	input  wire logic                                          hready,
	output logic      [31:0]                                   hrdata,
	output logic                                               hreadyout,
	output logic                                               hresp,
	// Per-link receive events
	input  wire lgi_pkg::lgi_link_evt_t [lgi_pkg::N_LINKS-1:0] link_evt,
	// Per-link counter wraps and FIFO overflow, and counter-block enables
	input  wire logic [lgi_pkg::N_LINKS-1:0][lgi_pkg::TC_W-1:0] tc_ovf_evt,
	input  wire logic [lgi_pkg::N_LINKS-1:0][lgi_pkg::TC_W-1:0] tc_ctr_irq_en,
	// Per-group overflow events and counter-block enables
	input  wire logic [lgi_pkg::N_GROUPS-1:0][lgi_pkg::GRP_W-1:0] grp_ovf_evt,
	input  wire logic [lgi_pkg::N_GROUPS-1:0][3:0]             grp_ctr_irq_en,
	// Per-group transmit control-cell events
	input  wire logic [lgi_pkg::N_GROUPS-1:0]                  ctl_xfer_done,
	input  wire logic [lgi_pkg::N_GROUPS-1:0]                  frame_end,
	// Interrupt pin
	output logic                                               irq_n
);

	if (LINKS < 1 || LINKS > lgi_pkg::N_LINKS) begin : g_chk
		$error("LINKS must lie between 1 and 16");
	end

	localparam int NL = lgi_pkg::N_LINKS;
	localparam int NG = lgi_pkg::N_GROUPS;
	localparam int LW = lgi_pkg::LST_W;
	localparam int TW = lgi_pkg::TC_W;
	localparam int GW = lgi_pkg::GRP_W;
	localparam int IW = lgi_pkg::IDX_W;

	// Bus state
	lgi_pkg::lgi_bus_st_t bus_st;
	logic [IW-1:0]        addr_q;
	logic                 take;
	logic                 wr_act;
	logic [15:0]          wd;
	logic [15:0]          rmux;

	// Software registers
	logic [NL-1:0][LW-1:0] link_en;
	logic [15:0]           master_en;
	logic [TW-1:0]         tc_en;
	logic [NG-1:0]         cc_en;
	logic [NG-1:0]         fe_en;
	logic [NG-1:0]         grp_en;
	logic [NG-1:0]         grp_fifo_en;

	// Status
	logic [NL-1:0][LW-1:0] link_lat;
	logic [NL-1:0][LW-1:0] link_stat;
	logic [NL-1:0][LW-1:0] link_clr;
	logic [NL-1:0][TW-1:0] tc_stat;
	logic [NL-1:0][TW-1:0] tc_clr;
	logic [NL-1:0][TW-1:0] tc_set;
	logic [NG-1:0][GW-1:0] grp_stat;
	logic [NG-1:0][GW-1:0] grp_clr;
	logic [15:0]           hnd;
	logic [15:0]           hnd_clr;
	logic [15:0]           hnd_set;
	logic [NG-1:0]         grp_act;
	logic [NG-1:0]         grp_sum;
	logic [NL-1:0]         master_stat;
	logic                  cc_frame;
	logic                  next_irq_n;

	// Address phase taken while the bus is ready
	assign take   = hsel & htrans[1] & hready;
	assign wr_act = (bus_st == lgi_pkg::BUS_WR);
	assign wd     = hwdata[15:0];
	assign hresp  = 1'b0;

	// Reads stall one cycle so read data is sampled after any prior write lands
	assign hreadyout = (bus_st != lgi_pkg::BUS_RD);

	// Bus phase tracking
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_st <= lgi_pkg::BUS_IDLE;
			addr_q <= '0;
		end else begin
			unique case (bus_st)
				lgi_pkg::BUS_IDLE, lgi_pkg::BUS_WR: begin
					if (take) begin
						addr_q <= haddr[IW+1:2];
						bus_st <= hwrite ? lgi_pkg::BUS_WR : lgi_pkg::BUS_RD;
					end else begin
						bus_st <= lgi_pkg::BUS_IDLE;
					end
				end
				lgi_pkg::BUS_RD: begin
					bus_st <= lgi_pkg::BUS_IDLE;
				end
			endcase
		end
	end

	// Read data captured in the stall cycle; reads have no side effects
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= '0;
		end else if (bus_st == lgi_pkg::BUS_RD) begin
			hrdata <= {16'h0000, rmux}; // R6
		end
	end

	// Plain read/write registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			master_en   <= lgi_pkg::RST_REG;
			tc_en       <= lgi_pkg::RST_REG[TW-1:0];
			cc_en       <= lgi_pkg::RST_REG[NG-1:0];
			fe_en       <= lgi_pkg::RST_REG[NG-1:0];
			grp_en      <= lgi_pkg::RST_REG[NG-1:0];
			grp_fifo_en <= lgi_pkg::RST_REG[NG-1:0];
		end else if (wr_act) begin
			if (addr_q == lgi_pkg::IDX_MASTER_EN) begin
				master_en <= wd;
			end
			if (addr_q == lgi_pkg::IDX_TC_EN) begin
				tc_en <= wd[TW-1:0];
			end
			if (addr_q == lgi_pkg::IDX_CC_EN) begin
				cc_en <= wd[NG-1:0]; // R13
			end
			if (addr_q == lgi_pkg::IDX_FE_EN) begin
				fe_en <= wd[NG-1:0]; // R13
			end
			if (addr_q == lgi_pkg::IDX_GRP_EN) begin
				grp_en <= wd[NG-1:0]; // R17
			end
			if (addr_q == lgi_pkg::IDX_GRP_FIFO_EN) begin
				grp_fifo_en <= wd[NG-1:0]; // R20
			end
		end
	end

	// Per-link enables, status latches, TC overflow status and summaries
	for (genvar i = 0; i < NL; i++) begin : g_link
		logic [LW-1:0] en_mask;
		logic          hit_en;
		logic          hit_st;
		logic          hit_tc;
		logic          tc_live;

		// Bits 7 and 8 only exist on link 0; links beyond LINKS stay quiet
		assign en_mask = (i == 0) ? {LW{1'b1}} : ~(LW'(1) << lgi_pkg::B_CC_FRAME |
			LW'(1) << lgi_pkg::B_GRP_OVF);
		assign hit_en  = wr_act && (addr_q == lgi_pkg::IDX_LINK_EN + IW'(i));
		assign hit_st  = wr_act && (addr_q == lgi_pkg::IDX_LINK_STAT + IW'(i));
		assign hit_tc  = wr_act && (addr_q == lgi_pkg::IDX_TC_STAT + IW'(i));

		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				link_en[i] <= lgi_pkg::RST_REG[LW-1:0];
			end else if (hit_en) begin
				link_en[i] <= wd[LW-1:0] & en_mask;
			end
		end

		// Only zeros on latched bits clear; bits 0, 7, 8 ignore writes
		assign link_clr[i] = hit_st ? (~wd[LW-1:0] & ~(LW'(1) << lgi_pkg::B_SUM) &
			en_mask) : '0; // R8 R9

		lgi_link_latch u_lat (
			.hclk    (hclk),
			.hresetn (hresetn),
			.evt     ((i < LINKS) ? link_evt[i] : '0),
			.clr     (link_clr[i]),
			.lat     (link_lat[i])
		);

		// TC overflow status: 12 FIFO, 11:8 input, 7:4 transmit, 3:0 receive
		assign tc_set[i] = (i < LINKS) ? tc_ovf_evt[i] : '0; // R15
		assign tc_clr[i] = hit_tc ? ~wd[TW-1:0] : '0;

		lgi_sticky #(
			.W (TW)
		) u_tc (
			.hclk    (hclk),
			.hresetn (hresetn),
			.set     (tc_set[i]),
			.clr     (tc_clr[i]),
			.stat    (tc_stat[i])
		);

		// Live counter/FIFO summary: masked by counter, TC enable or status clear
		assign tc_live = |(tc_stat[i] & tc_en & tc_ctr_irq_en[i]); // R4 R5 R7

		always_comb begin
			link_stat[i] = link_lat[i];
			link_stat[i][lgi_pkg::B_SUM] = tc_live; // R4
			if (i == 0) begin
				link_stat[i][lgi_pkg::B_CC_FRAME] = cc_frame; // R12
				link_stat[i][lgi_pkg::B_GRP_OVF]  = |grp_sum; // R11
			end
		end

		// A link counts as active only for enabled sources
		assign master_stat[i] = |(link_stat[i] & link_en[i]); // R10 R22
	end

	// Group overflow detail latches and summaries
	for (genvar g = 0; g < NG; g++) begin : g_grp
		logic hit;

		assign hit        = wr_act && (addr_q == lgi_pkg::IDX_GRP_STAT + IW'(g));
		assign grp_clr[g] = hit ? ~wd[GW-1:0] : '0; // R19

		lgi_sticky #(
			.W (GW)
		) u_grp (
			.hclk    (hclk),
			.hresetn (hresetn),
			.set     (grp_ovf_evt[g]), // R18
			.clr     (grp_clr[g]),
			.stat    (grp_stat[g])
		);

		// Counter sources need the counter enable, FIFO needs the group FIFO enable
		assign grp_act[g] = |(grp_stat[g][3:0] & grp_ctr_irq_en[g]) |
			(grp_stat[g][lgi_pkg::B_GRP_FIFO] & grp_fifo_en[g]); // R20 R11
		assign grp_sum[g] = grp_act[g] & grp_en[g]; // R16 R17
	end

	// Handler: ready bits 15:8 set on transfer completion, frame bits 7:0 on frame end
	assign hnd_set = {ctl_xfer_done, frame_end}; // R14
	assign hnd_clr = (wr_act && addr_q == lgi_pkg::IDX_HANDLER) ? ~wd : '0; // R14

	lgi_sticky #(
		.W (16)
	) u_hnd (
		.hclk    (hclk),
		.hresetn (hresetn),
		.set     (hnd_set),
		.clr     (hnd_clr),
		.stat    (hnd)
	);

	// Sixteen group sources merge into link 0 bit 7 under their own enables
	assign cc_frame = |(hnd[lgi_pkg::HND_READY +: NG] & cc_en) |
		|(hnd[NG-1:0] & fe_en); // R12 R13

	// Register read multiplexer
	always_comb begin
		rmux = '0;
		if (addr_q >= lgi_pkg::IDX_LINK_STAT && addr_q < lgi_pkg::IDX_LINK_STAT + IW'(NL)) begin
			rmux[LW-1:0] = link_stat[4'(addr_q - lgi_pkg::IDX_LINK_STAT)];
		end else if (addr_q >= lgi_pkg::IDX_LINK_EN &&
			addr_q < lgi_pkg::IDX_LINK_EN + IW'(NL)) begin
			rmux[LW-1:0] = link_en[4'(addr_q - lgi_pkg::IDX_LINK_EN)];
		end else if (addr_q >= lgi_pkg::IDX_TC_STAT &&
			addr_q < lgi_pkg::IDX_TC_STAT + IW'(NL)) begin
			rmux[TW-1:0] = tc_stat[4'(addr_q - lgi_pkg::IDX_TC_STAT)];
		end else if (addr_q >= lgi_pkg::IDX_GRP_STAT &&
			addr_q < lgi_pkg::IDX_GRP_STAT + IW'(NG)) begin
			rmux[GW-1:0] = grp_stat[3'(addr_q - lgi_pkg::IDX_GRP_STAT)];
		end else begin
			unique case (addr_q)
				lgi_pkg::IDX_HANDLER:     rmux = hnd;
				lgi_pkg::IDX_CC_EN:       rmux[NG-1:0] = cc_en;
				lgi_pkg::IDX_FE_EN:       rmux[NG-1:0] = fe_en;
				lgi_pkg::IDX_GRP_EN:      rmux[NG-1:0] = grp_en;
				lgi_pkg::IDX_GRP_FIFO_EN: rmux[NG-1:0] = grp_fifo_en;
				lgi_pkg::IDX_MASTER_EN:   rmux = master_en;
				lgi_pkg::IDX_TC_EN:       rmux[TW-1:0] = tc_en;
				lgi_pkg::IDX_MASTER_STAT: rmux[NL-1:0] = master_stat; // R22
				lgi_pkg::IDX_GRP_SUM:     rmux[NG-1:0] = grp_sum; // R16
				default:                  rmux = '0;
			endcase
		end
	end

	// Pin is a pure function of live state, so master status accesses never move it
	assign next_irq_n = ~|(master_stat & master_en[NL-1:0]); // R21 R22

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_n <= 1'b1;
		end else begin
			irq_n <= next_irq_n; // R21
		end
	end

endmodule

// file: lgi_pkg.sv
// Purpose: Shared constants and types for the link and group interrupt hierarchy.
// Assumes: Registers sit on one 32-bit AHB-Lite word each; byte address is four times the index.
// Notes: Status bits marked latched clear when written with zero; writing one leaves them alone.
//
// Overview of operation
// R1: Latch per-link status on entering delineation, frame or delay-sync loss (bits 1-3).
// R2: Latch per-link status when those three loss conditions end (bits 9-11).
// R3: Latch bit 4 on violation, bit 5 on changed cell, bit 6 on RAM overflow.
// R4: Bit 0 is a live summary of enabled counter or TC receive FIFO overflows.
// R5: A counter wrap raises a request only if its overflow interrupt is enabled.
// R6: Reading a link status register clears nothing.
// R7: Bit 0 drops on counter mask, TC status clear, or TC enable clear.
// R8: Writing zero clears latched bits 1-6 and 9-11; zero to bit 0 does nothing.
// R9: Writing one to link status bits leaves them unchanged.
// R10: A link source propagates only while its link enable bit is one.
// R11: Link 0 bit 8 live-summarises enabled group counter or FIFO overflows.
// R12: Link 0 bit 7 reports transfer completion or frame end for any group.
// R13: Two 8-bit enable registers gate transfer-complete and frame-end sources per group.
// R14: Handler ready bit sets on transfer completion; frame bits clear on write zero.
// R15: TC overflow status: bit 12 FIFO, 11:8 input, 7:4 transmit, 3:0 receive counters.
// R16: Group summary has one bit per group for any enabled latched overflow.
// R17: Group overflow enable bit lets that group's overflow reach upper levels.
// R18: Each group latches four transmit counter overflows and one receive FIFO overflow.
// R19: Group overflow status clears only on write zero; reads and ones change nothing.
// R20: Group receive FIFO overflow interrupts only when its group enable bit is set.
// R21: Interrupt pin goes low when any link is active and its master enable is one.
// R22: Master status shows live per-link activity; its accesses do not affect the pin.
// R23: Latched bits set regardless of enables; enables only gate upward propagation.
// R24: Software reads top-down, clears with zeros and re-enables masked sources.
package lgi_pkg;

	localparam int N_LINKS  = 16;
	localparam int N_GROUPS = 8;
	localparam int LST_W    = 12;
	localparam int TC_W     = 13;
	localparam int GRP_W    = 5;
	localparam int IDX_W    = 11;

	// Register indexes; byte address is index times four
	localparam logic [IDX_W-1:0] IDX_HANDLER     = 11'h086;
	localparam logic [IDX_W-1:0] IDX_CC_EN       = 11'h088;
	localparam logic [IDX_W-1:0] IDX_FE_EN       = 11'h089;
	localparam logic [IDX_W-1:0] IDX_GRP_EN      = 11'h40B;
	localparam logic [IDX_W-1:0] IDX_GRP_FIFO_EN = 11'h40C;
	localparam logic [IDX_W-1:0] IDX_TC_STAT     = 11'h410;
	localparam logic [IDX_W-1:0] IDX_GRP_STAT    = 11'h420;
	localparam logic [IDX_W-1:0] IDX_MASTER_EN   = 11'h433;
	localparam logic [IDX_W-1:0] IDX_TC_EN       = 11'h434;
	localparam logic [IDX_W-1:0] IDX_LINK_STAT   = 11'h435;
	localparam logic [IDX_W-1:0] IDX_LINK_EN     = 11'h445;
	localparam logic [IDX_W-1:0] IDX_MASTER_STAT = 11'h455;
	localparam logic [IDX_W-1:0] IDX_GRP_SUM     = 11'h457;

	// Link status bit positions
	localparam int B_SUM      = 0;
	localparam int B_DEL_LOSS = 1;
	localparam int B_FRM_LOSS = 2;
	localparam int B_DLY_LOSS = 3;
	localparam int B_VIOL     = 4;
	localparam int B_CHANGE   = 5;
	localparam int B_PRE_OVF  = 6;
	localparam int B_CC_FRAME = 7;
	localparam int B_GRP_OVF  = 8;
	localparam int B_DEL_END  = 9;
	localparam int B_FRM_END  = 10;
	localparam int B_DLY_END  = 11;

	// Group overflow detail: bits 3:0 transmit counters, bit 4 receive FIFO
	localparam int B_GRP_FIFO = 4;
	localparam int HND_READY  = 8;

	// Reset values
	localparam logic [15:0] RST_REG = 16'h0000;

	// Per-link event carrier; loss fields are levels, the rest one-cycle pulses
	typedef struct packed {
		logic delineation_loss;
		logic frame_loss;
		logic delay_sync_loss;
		logic control_cell_violation;
		logic ctrl_cell_change;
		logic preproc_overflow;
	} lgi_link_evt_t;

	typedef enum logic [2:0] {
		BUS_IDLE = 3'b001,
		BUS_WR   = 3'b010,
		BUS_RD   = 3'b100
	} lgi_bus_st_t;

endpackage

// file: lgi_link_latch.sv
// Purpose: Latched status bits of one receive link.
// Assumes: Event inputs come from logic on hclk; no synchronisers needed.
// Notes: Bits 0, 7 and 8 are live summaries built by the parent and read zero here.
`timescale 1ns/1ps
module lgi_link_latch (
	// Clock and reset
	input  wire logic                         hclk,
	input  wire logic                         hresetn,
	// Events and write-zero clear mask
	input  wire lgi_pkg::lgi_link_evt_t       evt,
	input  wire logic [lgi_pkg::LST_W-1:0]    clr,
	// Latched status
	output logic      [lgi_pkg::LST_W-1:0]    lat
);

	logic                        prev_del;
	logic                        prev_frm;
	logic                        prev_dly;
	logic [lgi_pkg::LST_W-1:0]   set;

	// Previous loss levels, for entry and end edges
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_del <= 1'b0;
			prev_frm <= 1'b0;
			prev_dly <= 1'b0;
		end else begin
			prev_del <= evt.delineation_loss;
			prev_frm <= evt.frame_loss;
			prev_dly <= evt.delay_sync_loss;
		end
	end

	// Set vector; enables are not consulted here so a masked source still records
	always_comb begin
		set = '0;
		set[lgi_pkg::B_DEL_LOSS] = evt.delineation_loss & ~prev_del; // R1
		set[lgi_pkg::B_FRM_LOSS] = evt.frame_loss & ~prev_frm; // R1
		set[lgi_pkg::B_DLY_LOSS] = evt.delay_sync_loss & ~prev_dly; // R1
		set[lgi_pkg::B_DEL_END]  = ~evt.delineation_loss & prev_del; // R2
		set[lgi_pkg::B_FRM_END]  = ~evt.frame_loss & prev_frm; // R2
		set[lgi_pkg::B_DLY_END]  = ~evt.delay_sync_loss & prev_dly; // R2
		set[lgi_pkg::B_VIOL]     = evt.control_cell_violation; // R3
		set[lgi_pkg::B_CHANGE]   = evt.ctrl_cell_change; // R3
		set[lgi_pkg::B_PRE_OVF]  = evt.preproc_overflow; // R3
	end

	// Set wins over a same-cycle clear so no event is lost
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lat <= '0;
		end else begin
			lat <= (lat & ~clr) | set; // R8 R9 R23
		end
	end

endmodule

// file: lgi_sticky.sv
// Purpose: Generic bank of sticky status bits cleared by writing zero.
// Assumes: Set pulses and clear mask are on hclk.
// Notes: Used for TC overflow, group overflow and handler bits.
`timescale 1ns/1ps
module lgi_sticky #(
	parameter int W = 5
) (
	// Clock and reset
	input  wire logic         hclk,
	input  wire logic         hresetn,
	// Set pulses and write-zero clear mask
	input  wire logic [W-1:0] set,
	input  wire logic [W-1:0] clr,
	// Status
	output logic      [W-1:0] stat
);

	if (W < 1) begin : g_chk
		$error("lgi_sticky width must be at least one");
	end

	// Set has priority over a clear arriving in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat <= '0;
		end else begin
			stat <= (stat & ~clr) | set; // R19 R23
		end
	end

endmodule

// file: lgi_irq_ctrl_chk.sv
// Purpose: Port-level checks of the interrupt hierarchy slave and its pin.
// Assumes: hready is tied to hreadyout; events come from logic on hclk.
// Notes: Pin moves are tied to a recent write, event or enable change.
`timescale 1ns/1ps
module lgi_irq_ctrl_chk (
	// Clock and reset
	input wire logic                          hclk,
	input wire logic                          hresetn,
	// AHB-Lite slave; address and write data are not watched
	input wire logic                          hsel,
	input wire logic [1:0]                    htrans,
	input wire logic                          hwrite,
	input wire logic                          hready,
	input wire logic [31:0]                   hrdata,
	input wire logic                          hreadyout,
	input wire logic                          hresp,
	// Events, enables and pin
	input wire lgi_pkg::lgi_link_evt_t [15:0] link_evt,
	input wire logic [15:0][12:0]             tc_ovf_evt,
	input wire logic [15:0][12:0]             tc_ctr_irq_en,
	input wire logic [7:0][4:0]               grp_ovf_evt,
	input wire logic [7:0][3:0]               grp_ctr_irq_en,
	input wire logic [7:0]                    ctl_xfer_done,
	input wire logic [7:0]                    frame_end,
	input wire logic                          irq_n
);
	logic       wdp;
	logic       wr_seen;
	logic [2:0] quiet;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Write data phase tracking and a flag for any completed write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wdp     <= 1'b0;
			wr_seen <= 1'b0;
		end else if (hready) begin
			wdp     <= hsel && htrans[1] && hwrite;
			wr_seen <= wr_seen || wdp;
		end
	end

	// Cycles since a possible cause of a pin move; saturates so it never wraps
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			quiet <= 3'h0;
		end else if ((wdp && hready) || (|tc_ovf_evt) || (|grp_ovf_evt) || (|ctl_xfer_done)
			|| (|frame_end) || $changed(link_evt) || $changed(tc_ctr_irq_en)
			|| $changed(grp_ctr_irq_en)) begin
			quiet <= 3'h0;
		end else if (quiet != 3'h7) begin
			quiet <= quiet + 3'h1;
		end
	end

	a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not OKAY");
	a_rdata_upper: assert property (hrdata[31:16] == 16'h0000) else $error("hrdata high set");
	a_write_nowait: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
		else $error("write stalled");
	a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite
		|=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
	a_rdata_hold: assert property (!$stable(hrdata) |-> !$past(hreadyout))
		else $error("hrdata moved outside read");
	a_reset_idle: assert property ($rose(hresetn) |-> irq_n && hreadyout)
		else $error("not idle after reset");
	a_irq_no_write: assert property (!wr_seen |-> irq_n) else $error("irq without enable");
	a_irq_fall_cause: assert property ($fell(irq_n) |-> quiet < 3'h4)
		else $error("irq fell with no cause");
	a_irq_rise_cause: assert property ($rose(irq_n) |-> quiet < 3'h4)
		else $error("irq rose with no cause");
endmodule

bind lgi_irq_ctrl lgi_irq_ctrl_chk lgi_irq_ctrl_chk_i (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .link_evt(link_evt), .tc_ovf_evt(tc_ovf_evt),
	.tc_ctr_irq_en(tc_ctr_irq_en), .grp_ovf_evt(grp_ovf_evt),
	.grp_ctr_irq_en(grp_ctr_irq_en), .ctl_xfer_done(ctl_xfer_done),
	.frame_end(frame_end), .irq_n(irq_n)
);

// file: lgi_cpu_model.sv
// Purpose: Processor model that services the interrupt hierarchy over AHB-Lite.
// Assumes: One slave, whose hreadyout is the bus hready.
// Notes: Waits on hready with no cycle count; the bench timeout ends a hang.
`timescale 1ns/1ps
module lgi_cpu_model (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite master
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [31:0]      hwdata,
	input  wire logic [31:0] hrdata,
	input  wire logic        hreadyout
);
	// Idle bus from time zero
	initial begin
		hsel   = 1'b1;
		haddr  = 32'h00000000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = 32'h00000000;
	end

	// One single word transfer, entered just after a rising edge
	task automatic xfer(input logic w, input logic [10:0] idx, input logic [15:0] d,
		output logic [31:0] q);
		htrans <= 2'b10;
		haddr  <= {19'h00000, idx, 2'b00};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= {16'h0000, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	// Top-down service: master status first, then each flagged link cleared by zeros
	task automatic service(output logic [31:0] ms);
		logic [31:0] q;
		xfer(1'b0, lgi_pkg::IDX_MASTER_STAT, 16'h0000, ms);
		for (int i = 0; i < 16; i++) begin
			if (ms[i]) begin
				xfer(1'b1, 11'(lgi_pkg::IDX_LINK_STAT + i), 16'h0000, q);
			end
		end
	endtask
endmodule

// file: lgi_irq_ctrl_bench.sv
// Purpose: Self-checking bench for the link and group interrupt hierarchy.
// Assumes: Events are driven on the rising edge; the processor model owns the bus.
// Notes: Links and groups are drawn at random from a fixed seed.
`timescale 1ns/1ps
module lgi_irq_ctrl_bench;
	logic                          hclk;
	logic                          hresetn;
	logic                          hsel, hwrite, hreadyout, hresp, irq_n;
	logic [1:0]                    htrans;
	logic [31:0]                   haddr, hwdata, hrdata, q;
	lgi_pkg::lgi_link_evt_t [15:0] link_evt;
	logic [15:0][12:0]             tc_ovf_evt;
	logic [15:0][12:0]             tc_ctr_irq_en;
	logic [7:0][4:0]               grp_ovf_evt;
	logic [7:0][3:0]               grp_ctr_irq_en;
	logic [7:0]                    ctl_xfer_done;
	logic [7:0]                    frame_end;
	int                            n_errors, check_count, cyc, ln, g;

	lgi_irq_ctrl lgi_irq_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link_evt(link_evt),
		.tc_ovf_evt(tc_ovf_evt), .tc_ctr_irq_en(tc_ctr_irq_en), .grp_ovf_evt(grp_ovf_evt),
		.grp_ctr_irq_en(grp_ctr_irq_en), .ctl_xfer_done(ctl_xfer_done),
		.frame_end(frame_end), .irq_n(irq_n));
	lgi_cpu_model lgi_cpu_model_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout));

	// 100 MHz clock
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	// Hang guard far above the few hundred cycles the tests need
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			end_of_test();
		end
	end

	function automatic logic [15:0] bit_of(int n);
		return 16'h0001 << n;
	endfunction
	function automatic logic [10:0] at(logic [10:0] base, int n);
		return base + 11'(n);
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [10:0] i, input logic [15:0] d);
		lgi_cpu_model_i.xfer(1'b1, i, d, q);
	endtask
	task automatic rd(input logic [10:0] i, input logic [15:0] exp);
		lgi_cpu_model_i.xfer(1'b0, i, 16'h0000, q);
		chk(q, {16'h0000, exp});
	endtask
	task automatic rs(input int n, input logic [15:0] exp);
		rd(at(lgi_pkg::IDX_LINK_STAT, n), exp);
	endtask
	task automatic ws(input int n, input logic [15:0] d);
		wr(at(lgi_pkg::IDX_LINK_STAT, n), d);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		hresetn = 1'b0;
		link_evt = '0;
		tc_ovf_evt = '0;
		tc_ctr_irq_en = '1;
		grp_ovf_evt = '0;
		grp_ctr_irq_en = '1;
		ctl_xfer_done = '0;
		frame_end = '0;
		void'($urandom(32'h8EAF9D8A));
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// Reset values and an unmapped word
		rs(0, lgi_pkg::RST_REG);
		rd(lgi_pkg::IDX_HANDLER, lgi_pkg::RST_REG);
		rd(lgi_pkg::IDX_GRP_SUM, lgi_pkg::RST_REG);
		rd(11'h7FF, 16'h0000);
		chk(irq_n, 1'b1);
		// Loss entry, pulses and loss end on a link with all enables off
		ln = $urandom_range(15, 1);
		link_evt[ln] <= 6'h3F;
		@(posedge hclk);
		link_evt[ln] <= 6'h38;
		@(posedge hclk);
		rs(ln, 16'h007E);
		rs(ln, 16'h007E);
		rd(lgi_pkg::IDX_MASTER_STAT, 16'h0000);
		link_evt[ln] <= 6'h00;
		@(posedge hclk);
		rs(ln, 16'h0E7E);
		ws(ln, 16'hFFFF);
		rs(ln, 16'h0E7E);
		ws(ln, 16'hFFFD);
		rs(ln, 16'h0E7C);
		wr(at(lgi_pkg::IDX_LINK_EN, ln), 16'h0004);
		rd(lgi_pkg::IDX_MASTER_STAT, bit_of(ln));
		wr(lgi_pkg::IDX_MASTER_EN, bit_of(ln));
		repeat (2) @(posedge hclk);
		chk(irq_n, 1'b0);
		wr(lgi_pkg::IDX_MASTER_STAT, 16'h0000);
		rd(lgi_pkg::IDX_MASTER_STAT, bit_of(ln));
		chk(irq_n, 1'b0);
		lgi_cpu_model_i.service(q);
		chk(q, {16'h0000, bit_of(ln)});
		rs(ln, 16'h0000);
		chk(irq_n, 1'b1);
		// Every TC overflow source on random links lands on its own bit
		for (int i = 0; i < 13; i++) begin
			ln = $urandom_range(15, 0);
			tc_ovf_evt[ln][i] <= 1'b1;
			@(posedge hclk);
			tc_ovf_evt[ln][i] <= 1'b0;
			rd(at(lgi_pkg::IDX_TC_STAT, ln), bit_of(i));
			wr(at(lgi_pkg::IDX_TC_STAT, ln), 16'h0000);
		end
		// Link summary bit and the three ways it drops
		ln = $urandom_range(15, 1);
		wr(lgi_pkg::IDX_TC_EN, 16'h1FFF);
		tc_ovf_evt[ln][5] <= 1'b1;
		@(posedge hclk);
		tc_ovf_evt[ln][5] <= 1'b0;
		rs(ln, 16'h0001);
		ws(ln, 16'h0000);
		rs(ln, 16'h0001);
		tc_ctr_irq_en[ln][5] <= 1'b0;
		@(posedge hclk);
		rs(ln, 16'h0000);
		tc_ctr_irq_en[ln][5] <= 1'b1;
		wr(lgi_pkg::IDX_TC_EN, 16'h0000);
		rs(ln, 16'h0000);
		wr(lgi_pkg::IDX_TC_EN, 16'h1FFF);
		wr(at(lgi_pkg::IDX_TC_STAT, ln), 16'h0000);
		rs(ln, 16'h0000);
		// Group overflow levels and link 0 bit 8
		g = $urandom_range(7, 0);
		grp_ovf_evt[g] <= 5'h11;
		@(posedge hclk);
		grp_ovf_evt[g] <= 5'h00;
		rd(at(lgi_pkg::IDX_GRP_STAT, g), 16'h0011);
		rd(lgi_pkg::IDX_GRP_SUM, 16'h0000);
		grp_ctr_irq_en[g] <= 4'h0;
		wr(lgi_pkg::IDX_GRP_EN, bit_of(g));
		rd(lgi_pkg::IDX_GRP_SUM, 16'h0000);
		wr(lgi_pkg::IDX_GRP_FIFO_EN, bit_of(g));
		rd(lgi_pkg::IDX_GRP_SUM, bit_of(g));
		rs(0, 16'h0100);
		wr(at(lgi_pkg::IDX_GRP_STAT, g), 16'hFFFF);
		rd(at(lgi_pkg::IDX_GRP_STAT, g), 16'h0011);
		wr(lgi_pkg::IDX_GRP_FIFO_EN, 16'h0000);
		rs(0, 16'h0000);
		grp_ctr_irq_en[g] <= 4'hF;
		@(posedge hclk);
		rd(lgi_pkg::IDX_GRP_SUM, bit_of(g));
		wr(at(lgi_pkg::IDX_GRP_STAT, g), 16'h0000);
		rd(at(lgi_pkg::IDX_GRP_STAT, g), 16'h0000);
		// Transfer-complete and frame-end sources behind link 0 bit 7
		g = $urandom_range(7, 0);
		ctl_xfer_done[g] <= 1'b1;
		@(posedge hclk);
		ctl_xfer_done[g] <= 1'b0;
		rd(lgi_pkg::IDX_HANDLER, bit_of(8 + g));
		rs(0, 16'h0000);
		wr(lgi_pkg::IDX_CC_EN, bit_of(g));
		rs(0, 16'h0080);
		frame_end[g] <= 1'b1;
		@(posedge hclk);
		frame_end[g] <= 1'b0;
		rd(lgi_pkg::IDX_HANDLER, bit_of(8 + g) | bit_of(g));
		wr(lgi_pkg::IDX_CC_EN, 16'h0000);
		wr(lgi_pkg::IDX_FE_EN, bit_of(g));
		rs(0, 16'h0080);
		wr(lgi_pkg::IDX_HANDLER, 16'h0000);
		rd(lgi_pkg::IDX_HANDLER, 16'h0000);
		rs(0, 16'h0000);
		end_of_test();
	end
endmodule
